/* design/dtc_dual_timer.v */
// Dual 16-bit timer/counter with external interrupt flags.
// Assumes a byte-wide register port from the core on clk, and
// asynchronous pins that are synchronised here before use.
`timescale 1ns/1ns
`include "dtc_defines.vh"

// Summary of operation
// - Timer 1 gate needs its interrupt pin high
// - Timer 0 gate needs its interrupt pin high
// - Timer 1 select: pin events or machine cycles
// - Timer 0 select: pin events or machine cycles
// - Timer 1 mode 00: 5-bit prescaler, 8-bit counter
// - Timer 1 mode 01: cascaded 16-bit counter
// - Timer 1 mode 10: 8-bit auto-reload from high
// - Timer 1 mode 11: stopped, holds value
// - Timer 0 mode 00: 5-bit prescaler, 8-bit counter
// - Timer 0 mode 01: cascaded 16-bit counter
// - Timer 0 mode 10: 8-bit auto-reload from high
// - Timer 0 mode 11: low byte own 8-bit counter
// - Timer 1 overflow sets flag, vectoring clears
// - Timer 0 overflow sets flag, vectoring clears
// - Timer 1 run bit turns it on/off
// - Timer 0 run bit turns it on/off
// - Interrupt 1 flag: edge or level, clear rules
// - Interrupt 0 flag: edge or level, clear rules
// - Trigger bit one edge, zero level
// - Two count bytes, separate or combined
// - Timer ticks once per twelve clocks
// - Counter samples pin once per machine cycle
// - Prescaled count is high plus five low
// - Split high byte uses timer 1 run/flag
module dtc_dual_timer (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Register port
  input  wire [7:0] sfr_addr,
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  input  wire [7:0] sfr_wdata,
  output reg  [7:0] sfr_rdata,
  output wire       sfr_sel,
  // Interrupt vectoring acknowledges
  input  wire       ack_timer0,
  input  wire       ack_timer1,
  input  wire       ack_ext_irq0,
  input  wire       ack_ext_irq1,
  // Pins
  input  wire       ext_irq0_pin,
  input  wire       ext_irq1_pin,
  input  wire       timer0_count_pin,
  input  wire       timer1_count_pin,
  // Interrupt request flags
  output wire       timer0_overflow_flag,
  output wire       timer1_overflow_flag,
  output wire       ext_irq0_flag,
  output wire       ext_irq1_flag,
  // Timer 1 overflow for baud use
  output wire       timer1_ovf_pulse
);

  // ==========================================================
  // Registers and internal signals
  reg  [7:0] timer_mode_select;
  reg  [7:0] timer_control_flags;
  reg  [3:0] pin_meta;
  reg  [3:0] pin_sync;
  reg  [1:0] cnt_sample;
  reg  [1:0] irq_prev;
  reg  [3:0] mc_cnt;
  reg  [7:0] next_ctrl;
  reg  [7:0] next_rdata;
  wire       mc_tick;
  wire       ext_irq0_pin_lvl;
  wire       ext_irq1_pin_lvl;
  wire       cnt0_lvl;
  wire       cnt1_lvl;
  wire       cnt0_edge;
  wire       cnt1_edge;
  wire       run0;
  wire       run1;
  wire       split0;
  wire       inc_lo0;
  wire       inc_lo1;
  wire       inc_hi0;
  wire       set_tf0;
  wire       set_tf1;
  wire       set_ie0;
  wire       set_ie1;
  wire       wr_ctrl;
  wire       wr_mode;
  wire [7:0] timer0_count_low;
  wire [7:0] timer0_count_high;
  wire [7:0] timer1_count_low;
  wire [7:0] timer1_count_high;
  wire       ovf0;
  wire       ovf0_hi;
  wire       ovf1;

  // Mode register fields
  wire       gate1 = timer_mode_select[`DTC_MODE_GATE1];
  wire       sel1  = timer_mode_select[`DTC_MODE_CT1];
  wire [1:0] mode1 = timer_mode_select[`DTC_MODE_M1_HI:`DTC_MODE_M1_LO];
  wire       gate0 = timer_mode_select[`DTC_MODE_GATE0];
  wire       sel0  = timer_mode_select[`DTC_MODE_CT0];
  wire [1:0] mode0 = timer_mode_select[`DTC_MODE_M0_HI:`DTC_MODE_M0_LO];

  // Control register fields
  wire       timer1_run = timer_control_flags[`DTC_CTRL_TR1];
  wire       timer0_run = timer_control_flags[`DTC_CTRL_TR0];

  // ==========================================================
  // Pin synchronisers: bit 0 ext_irq0_pin, 1 ext_irq1_pin, 2 count0, 3 count1
  // Reset to the pulled-up idle level, so no false low follows reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= `DTC_RST_PINS;
      pin_sync <= `DTC_RST_PINS;
    end else begin
      pin_meta <= {timer1_count_pin, timer0_count_pin,
                   ext_irq1_pin, ext_irq0_pin};
      pin_sync <= pin_meta;
    end
  end

  assign ext_irq0_pin_lvl = pin_sync[0];
  assign ext_irq1_pin_lvl = pin_sync[1];
  assign cnt0_lvl = pin_sync[2];
  assign cnt1_lvl = pin_sync[3];

  // ==========================================================
  // Machine cycle divider
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mc_cnt <= 4'h0;
    end else if (mc_tick) begin
      mc_cnt <= 4'h0;
    end else begin
      mc_cnt <= mc_cnt + 4'h1;
    end
  end

  assign mc_tick = (mc_cnt == (`DTC_MC_CLOCKS - 4'h1));

  // ==========================================================
  // Count pins sampled once per machine cycle, so an input level
  // must be held a full machine cycle to be seen reliably.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_sample <= 2'h0;
    end else if (mc_tick) begin
      cnt_sample <= {cnt1_lvl, cnt0_lvl};
    end
  end

  assign cnt0_edge = mc_tick & cnt_sample[0] & ~cnt0_lvl;
  assign cnt1_edge = mc_tick & cnt_sample[1] & ~cnt1_lvl;

  // ==========================================================
  // Run enables and count sources
  assign split0 = (mode0 == `DTC_MODE_SPLIT);

  assign run0 = timer0_run & (~gate0 | ext_irq0_pin_lvl);
  // While timer 0 is split, timer 1 loses its run bit and is
  // switched by leaving or entering its own hold mode, and by its gate pin when gate1 is set.
  assign run1 = (timer1_run | split0) & (~gate1 | ext_irq1_pin_lvl);

  assign inc_lo0 = run0 & (sel0 ? cnt0_edge : mc_tick);
  assign inc_lo1 = run1 & (sel1 ? cnt1_edge : mc_tick);
  assign inc_hi0 = split0 & timer1_run & mc_tick;

  // ==========================================================
  // Timer instances
  dtc_timer #(
    .SPLIT_OK (1)
  ) u_timer0 (
    .clk      (clk),
    .rst_n    (rst_n),
    .mode     (mode0),
    .inc_lo   (inc_lo0),
    .inc_hi   (inc_hi0),
    .wr_lo    (sfr_wr && sfr_addr == `DTC_ADDR_T0_LOW),
    .wr_hi    (sfr_wr && sfr_addr == `DTC_ADDR_T0_HIGH),
    .wdata    (sfr_wdata),
    .count_lo (timer0_count_low),
    .count_hi (timer0_count_high),
    .ovf      (ovf0),
    .ovf_hi   (ovf0_hi)
  );

  dtc_timer #(
    .SPLIT_OK (0)
  ) u_timer1 (
    .clk      (clk),
    .rst_n    (rst_n),
    .mode     (mode1),
    .inc_lo   (inc_lo1),
    .inc_hi   (1'b0),
    .wr_lo    (sfr_wr && sfr_addr == `DTC_ADDR_T1_LOW),
    .wr_hi    (sfr_wr && sfr_addr == `DTC_ADDR_T1_HIGH),
    .wdata    (sfr_wdata),
    .count_lo (timer1_count_low),
    .count_hi (timer1_count_high),
    .ovf      (ovf1),
    .ovf_hi   ()
  );

  assign timer1_ovf_pulse = ovf1;

  // ==========================================================
  // Flag set sources
  assign set_tf0 = ovf0;
  assign set_tf1 = split0 ? ovf0_hi : ovf1;

  // Edge detection runs on the synchronised level
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_prev <= 2'h3;
    end else begin
      irq_prev <= {ext_irq1_pin_lvl, ext_irq0_pin_lvl};
    end
  end

  assign set_ie0 = irq_prev[0] & ~ext_irq0_pin_lvl;
  assign set_ie1 = irq_prev[1] & ~ext_irq1_pin_lvl;

  // ==========================================================
  // Control/flags register: hardware set wins over any clear
  assign wr_ctrl = sfr_wr && (sfr_addr == `DTC_ADDR_CTRL);
  assign wr_mode = sfr_wr && (sfr_addr == `DTC_ADDR_MODE);

  always @* begin
    next_ctrl = timer_control_flags;
    if (wr_ctrl) begin
      next_ctrl = sfr_wdata;
    end
    if (ack_timer1 && !wr_ctrl) begin
      next_ctrl[`DTC_CTRL_TF1] = 1'b0;
    end
    if (ack_timer0 && !wr_ctrl) begin
      next_ctrl[`DTC_CTRL_TF0] = 1'b0;
    end
    if (set_tf1) begin
      next_ctrl[`DTC_CTRL_TF1] = 1'b1;
    end
    if (set_tf0) begin
      next_ctrl[`DTC_CTRL_TF0] = 1'b1;
    end
    // Level mode: the pin owns the flag, software cannot hold it
    if (!next_ctrl[`DTC_CTRL_IT1]) begin
      next_ctrl[`DTC_CTRL_IE1] = ~ext_irq1_pin_lvl;
    end else begin
      if (ack_ext_irq1 && !wr_ctrl) begin
        next_ctrl[`DTC_CTRL_IE1] = 1'b0;
      end
      if (set_ie1) begin
        next_ctrl[`DTC_CTRL_IE1] = 1'b1;
      end
    end
    if (!next_ctrl[`DTC_CTRL_IT0]) begin
      next_ctrl[`DTC_CTRL_IE0] = ~ext_irq0_pin_lvl;
    end else begin
      if (ack_ext_irq0 && !wr_ctrl) begin
        next_ctrl[`DTC_CTRL_IE0] = 1'b0;
      end
      if (set_ie0) begin
        next_ctrl[`DTC_CTRL_IE0] = 1'b1;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_flags <= `DTC_RST_CTRL;
      timer_mode_select   <= `DTC_RST_MODE;
    end else begin
      timer_control_flags <= next_ctrl;
      if (wr_mode) begin
        timer_mode_select <= sfr_wdata;
      end
    end
  end

  assign timer0_overflow_flag = timer_control_flags[`DTC_CTRL_TF0];
  assign timer1_overflow_flag = timer_control_flags[`DTC_CTRL_TF1];
  assign ext_irq0_flag        = timer_control_flags[`DTC_CTRL_IE0];
  assign ext_irq1_flag        = timer_control_flags[`DTC_CTRL_IE1];

  // ==========================================================
  // Read path, registered; unclaimed addresses read zero
  assign sfr_sel = (sfr_addr == `DTC_ADDR_CTRL)    ||
                   (sfr_addr == `DTC_ADDR_MODE)    ||
                   (sfr_addr == `DTC_ADDR_T0_LOW)  ||
                   (sfr_addr == `DTC_ADDR_T1_LOW)  ||
                   (sfr_addr == `DTC_ADDR_T0_HIGH) ||
                   (sfr_addr == `DTC_ADDR_T1_HIGH);

  always @* begin
    case (sfr_addr)
      `DTC_ADDR_CTRL:    next_rdata = timer_control_flags;
      `DTC_ADDR_MODE:    next_rdata = timer_mode_select;
      `DTC_ADDR_T0_LOW:  next_rdata = timer0_count_low;
      `DTC_ADDR_T1_LOW:  next_rdata = timer1_count_low;
      `DTC_ADDR_T0_HIGH: next_rdata = timer0_count_high;
      `DTC_ADDR_T1_HIGH: next_rdata = timer1_count_high;
      default:           next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= next_rdata;
    end
  end

endmodule // dtc_dual_timer

/* design/dtc_defines.vh */
// Constants for the dual timer/counter: register addresses, bit
// positions, mode codes and reset values.
// Assumes it is included by bare name from the design files.
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// ==========================================================
// Register addresses on the core register port
`define DTC_ADDR_CTRL      8'h88
`define DTC_ADDR_MODE      8'h89
`define DTC_ADDR_T0_LOW    8'h8A
`define DTC_ADDR_T1_LOW    8'h8B
`define DTC_ADDR_T0_HIGH   8'h8C
`define DTC_ADDR_T1_HIGH   8'h8D

// ==========================================================
// Reset values
`define DTC_RST_CTRL       8'h00
`define DTC_RST_MODE       8'h00
`define DTC_RST_COUNT      8'h00
`define DTC_RST_PINS       4'hF

// ==========================================================
// Control/flags register bit positions
`define DTC_CTRL_TF1       7
`define DTC_CTRL_TR1       6
`define DTC_CTRL_TF0       5
`define DTC_CTRL_TR0       4
`define DTC_CTRL_IE1       3
`define DTC_CTRL_IT1       2
`define DTC_CTRL_IE0       1
`define DTC_CTRL_IT0       0

// ==========================================================
// Mode select register bit positions
`define DTC_MODE_GATE1     7
`define DTC_MODE_CT1       6
`define DTC_MODE_M1_HI     5
`define DTC_MODE_M1_LO     4
`define DTC_MODE_GATE0     3
`define DTC_MODE_CT0       2
`define DTC_MODE_M0_HI     1
`define DTC_MODE_M0_LO     0

// ==========================================================
// Mode field codes
`define DTC_MODE_PRESCALE  2'h0
`define DTC_MODE_CASCADE   2'h1
`define DTC_MODE_RELOAD    2'h2
`define DTC_MODE_SPLIT     2'h3

// ==========================================================
// Timing: core clocks per machine cycle
`define DTC_MC_CLOCKS      4'hC

`endif

/* design/dtc_timer.v */
// One timer/counter: low and high count bytes with mode logic.
// Assumes increment strobes are one-cycle pulses on clk and that
// byte writes come from the register port on the same clock.
`timescale 1ns/1ns
`include "dtc_defines.vh"

module dtc_timer #(
  parameter SPLIT_OK = 1
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Control
  input  wire [1:0] mode,
  input  wire       inc_lo,
  input  wire       inc_hi,
  // Software byte writes
  input  wire       wr_lo,
  input  wire       wr_hi,
  input  wire [7:0] wdata,
  // Count and overflow pulses
  output reg  [7:0] count_lo,
  output reg  [7:0] count_hi,
  output reg        ovf,
  output reg        ovf_hi
);

  // Sum in the low eight bits, carry out on top
  function [8:0] dtc_inc8;
    input [7:0] value;
    begin
      dtc_inc8 = {1'b0, value} + 9'h001;
    end
  endfunction

  reg [7:0] next_lo;
  reg [7:0] next_hi;
  reg       next_ovf;
  reg       next_ovf_hi;
  reg [8:0] sum_lo;
  reg [8:0] sum_hi;

  // ==========================================================
  // Next count
  always @* begin
    next_lo     = count_lo;
    next_hi     = count_hi;
    next_ovf    = 1'b0;
    next_ovf_hi = 1'b0;
    sum_lo      = dtc_inc8(count_lo);
    sum_hi      = dtc_inc8(count_hi);
    case (mode)
      `DTC_MODE_PRESCALE: begin
        // Upper three low-byte bits are left alone
        if (inc_lo) begin
          next_lo[4:0] = sum_lo[4:0];
          if (count_lo[4:0] == 5'h1F) begin
            next_hi  = sum_hi[7:0];
            next_ovf = sum_hi[8];
          end
        end
      end
      `DTC_MODE_CASCADE: begin
        if (inc_lo) begin
          next_lo = sum_lo[7:0];
          if (sum_lo[8]) begin
            next_hi  = sum_hi[7:0];
            next_ovf = sum_hi[8];
          end
        end
      end
      `DTC_MODE_RELOAD: begin
        if (inc_lo) begin
          if (sum_lo[8]) begin
            next_lo  = count_hi;
            next_ovf = 1'b1;
          end else begin
            next_lo = sum_lo[7:0];
          end
        end
      end
      `DTC_MODE_SPLIT: begin
        // Timer 1 simply holds here; timer 0 splits in two bytes
        if (SPLIT_OK != 0) begin
          if (inc_lo) begin
            next_lo  = sum_lo[7:0];
            next_ovf = sum_lo[8];
          end
          if (inc_hi) begin
            next_hi     = sum_hi[7:0];
            next_ovf_hi = sum_hi[8];
          end
        end else begin
          next_lo = count_lo;
        end
      end
      default: begin
        next_lo = count_lo;
      end
    endcase
    // Software write takes the byte at once
    if (wr_lo) begin
      next_lo = wdata;
    end
    if (wr_hi) begin
      next_hi = wdata;
    end
  end

  // ==========================================================
  // Count registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_lo <= `DTC_RST_COUNT;
      count_hi <= `DTC_RST_COUNT;
      ovf      <= 1'b0;
      ovf_hi   <= 1'b0;
    end else begin
      count_lo <= next_lo;
      count_hi <= next_hi;
      ovf      <= next_ovf;
      ovf_hi   <= next_ovf_hi;
    end
  end

endmodule // dtc_timer

/* verification/dtc_dual_timer_sva.sv */
// Checker for the dual timer/counter, watching only top-level ports.
// Assumes machine cycles are counted from reset release, as in the core.
`timescale 1ns/1ns
`include "dtc_defines.vh"

module dtc_dual_timer_sva (
  // Clock and reset
  input wire       clk,
  input wire       rst_n,
  // Register port
  input wire [7:0] sfr_addr,
  input wire       sfr_wr,
  input wire       sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  input wire       sfr_sel,
  // Acknowledges
  input wire       ack_timer0,
  input wire       ack_timer1,
  input wire       ack_ext_irq0,
  input wire       ack_ext_irq1,
  // Pins
  input wire       ext_irq0_pin,
  input wire       ext_irq1_pin,
  input wire       timer0_count_pin,
  input wire       timer1_count_pin,
  // Flags
  input wire       timer0_overflow_flag,
  input wire       timer1_overflow_flag,
  input wire       ext_irq0_flag,
  input wire       ext_irq1_flag,
  input wire       timer1_ovf_pulse
);
  // ==========================================================
  // Machine-cycle phase and shadow of the trigger-type bits
  logic [3:0] mc;
  logic       it0;
  logic       it1;
  wire        wr_ctrl = sfr_wr && sfr_addr == `DTC_ADDR_CTRL;
  wire        mapped  = sfr_addr >= `DTC_ADDR_CTRL &&
                        sfr_addr <= `DTC_ADDR_T1_HIGH;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mc  <= 4'h0;
      it0 <= 1'b0;
      it1 <= 1'b0;
    end else begin
      mc <= (mc == 4'hB) ? 4'h0 : mc + 4'h1;
      if (wr_ctrl) begin
        it0 <= sfr_wdata[`DTC_CTRL_IT0];
        it1 <= sfr_wdata[`DTC_CTRL_IT1];
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Assertions
  chk_sel_decode: assert property (sfr_sel == mapped)
    else $error("select decode wrong");
  chk_unmapped_read: assert property (
    sfr_rd && !mapped |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without read");
  // Overflow pulse stands in the cycle after the tick edge (phase 0);
  // the flag it sets is first seen one edge later (phase 1).
  chk_tf0_phase: assert property (
    $rose(timer0_overflow_flag) && !$past(wr_ctrl) |-> mc == 4'h1)
    else $error("timer0 flag set off tick");
  chk_tf1_phase: assert property (
    $rose(timer1_overflow_flag) && !$past(wr_ctrl) |-> mc == 4'h1)
    else $error("timer1 flag set off tick");
  chk_pulse_phase: assert property (timer1_ovf_pulse |-> mc == 4'h0)
    else $error("overflow pulse off tick");
  chk_pulse_single: assert property (
    timer1_ovf_pulse |=> !timer1_ovf_pulse [*8])
    else $error("overflow pulse too long");
  chk_tf0_ack_clear: assert property (
    timer0_overflow_flag && ack_timer0 && !wr_ctrl && mc > 4'h2
    |=> !timer0_overflow_flag)
    else $error("timer0 flag kept after ack");
  chk_edge_ack_clear: assert property (
    ext_irq1_pin [*5] ##0 (it1 && ack_ext_irq1 && !wr_ctrl)
    |=> !ext_irq1_flag)
    else $error("edge flag kept after ack");
  chk_edge_no_set: assert property (
    ext_irq0_pin [*5] ##0 (it0 && !ext_irq0_flag && !wr_ctrl)
    |=> !ext_irq0_flag)
    else $error("edge flag set without edge");
  chk_level_low: assert property (
    (!it0 && !ext_irq0_pin && !wr_ctrl) [*5] |-> ext_irq0_flag)
    else $error("level flag clear on low pin");
  chk_level_high: assert property (
    (!it1 && ext_irq1_pin && !wr_ctrl) [*5] |-> !ext_irq1_flag)
    else $error("level flag set on high pin");

  cov_pulse: cover property (timer1_ovf_pulse);
  cov_tf0: cover property ($rose(timer0_overflow_flag));
  cov_edge_ack: cover property (ack_ext_irq1 && ext_irq1_flag);
endmodule // dtc_dual_timer_sva

bind dtc_dual_timer dtc_dual_timer_sva u_sva (
  .clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
  .sfr_sel, .ack_timer0, .ack_timer1, .ack_ext_irq0, .ack_ext_irq1,
  .ext_irq0_pin, .ext_irq1_pin, .timer0_count_pin, .timer1_count_pin,
  .timer0_overflow_flag, .timer1_overflow_flag, .ext_irq0_flag,
  .ext_irq1_flag, .timer1_ovf_pulse
);

/* verification/dtc_pin_model.sv */
// Far-side pin model: interrupt and count pins behind port pull-ups.
// Assumes the bench calls its tasks; pins change on falling edges.
`timescale 1ns/1ns

module dtc_pin_model (
  // Clock
  input  wire  clk,
  // Pins
  output logic ext_irq0_pin,
  output logic ext_irq1_pin,
  output logic timer0_count_pin,
  output logic timer1_count_pin
);
  // ==========================================================
  // Pull-ups keep idle pins high
  initial begin
    ext_irq0_pin     = 1'b1;
    ext_irq1_pin     = 1'b1;
    timer0_count_pin = 1'b1;
    timer1_count_pin = 1'b1;
  end

  task automatic set_irq(input int which, input logic level);
    @(negedge clk);
    if (which == 0)
      ext_irq0_pin = level;
    else
      ext_irq1_pin = level;
  endtask

  // Levels last two machine cycles so a sample always lands on each
  task automatic count_pulses(input int which, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(negedge clk);
      if (which == 0)
        timer0_count_pin = i[0];
      else
        timer1_count_pin = i[0];
      repeat (23) @(negedge clk);
    end
  endtask
endmodule // dtc_pin_model

/* verification/tb_dtc_dual_timer.sv */
// Testbench for the dual timer/counter through its register port.
// Assumes the checker binds itself and the pin model idles high.
`timescale 1ns/1ns
`include "dtc_defines.vh"

module tb_dtc_dual_timer;
  // ==========================================================
  // Signals
  logic       clk          = 1'b0;
  logic       rst_n        = 1'b0;
  logic [7:0] sfr_addr     = 8'h00;
  logic       sfr_wr       = 1'b0;
  logic       sfr_rd       = 1'b0;
  logic [7:0] sfr_wdata    = 8'h00;
  logic       ack_timer0   = 1'b0;
  logic       ack_timer1   = 1'b0;
  logic       ack_ext_irq0 = 1'b0;
  logic       ack_ext_irq1 = 1'b0;
  wire  [7:0] sfr_rdata;
  wire        sfr_sel, timer1_ovf_pulse;
  wire        timer0_overflow_flag, timer1_overflow_flag;
  wire        ext_irq0_flag, ext_irq1_flag;
  wire        ext_irq0_pin, ext_irq1_pin;
  wire        timer0_count_pin, timer1_count_pin;
  logic [3:0] mc;
  int         miscompares  = 0;
  int         compares     = 0;
  int         cycles       = 0;

  dtc_dual_timer u_dut (
    .clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .sfr_sel, .ack_timer0, .ack_timer1, .ack_ext_irq0, .ack_ext_irq1,
    .ext_irq0_pin, .ext_irq1_pin, .timer0_count_pin, .timer1_count_pin,
    .timer0_overflow_flag, .timer1_overflow_flag, .ext_irq0_flag,
    .ext_irq1_flag, .timer1_ovf_pulse
  );
  dtc_pin_model u_pins (
    .clk, .ext_irq0_pin, .ext_irq1_pin, .timer0_count_pin, .timer1_count_pin
  );

  always #20 clk = ~clk;

  // Phase is tracked so runs start away from the tick edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      mc <= 4'h0;
    else
      mc <= (mc == 4'hB) ? 4'h0 : mc + 4'h1;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      report_and_stop();
    end
  end

  // ==========================================================
  // Tasks
  task automatic report_and_stop();
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string w, input logic [7:0] seen,
                       input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", w, exp, seen);
    end
  endtask

  task automatic flag(input string w, input logic seen, input logic exp);
    check(w, {7'h00, seen}, {7'h00, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    check($sformatf("register %h", a), sfr_rdata, exp);
    @(negedge clk);
  endtask

  task automatic ack_pulse(input logic [3:0] k);
    {ack_ext_irq1, ack_ext_irq0, ack_timer1, ack_timer0} = k;
    @(negedge clk);
    {ack_ext_irq1, ack_ext_irq0, ack_timer1, ack_timer0} = 4'h0;
    @(negedge clk);
  endtask

  // Exactly n ticks fall between the start write and the return
  task automatic run(input logic [7:0] on, input int n);
    while (mc != 4'h4)
      @(negedge clk);
    wr(`DTC_ADDR_CTRL, on);
    repeat (12 * n - 2) @(negedge clk);
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    for (int a = 8'h88; a <= 8'h8E; a++) begin
      rd(a[7:0], 8'h00);
      flag("select", sfr_sel, a != 8'h8E);
    end
    for (int a = 8'h89; a <= 8'h8E; a++) begin
      wr(a[7:0], 8'hA0 | a[7:0]);
      rd(a[7:0], (a == 8'h8E) ? 8'h00 : 8'hA0 | a[7:0]);
    end
    wr(`DTC_ADDR_MODE, 8'h01);
    wr(`DTC_ADDR_T0_LOW, 8'hFE);
    wr(`DTC_ADDR_T0_HIGH, 8'hFF);
    run(8'h10, 3);
    flag("timer0 flag", timer0_overflow_flag, 1'b1);
    ack_pulse(4'h1);
    flag("timer0 flag", timer0_overflow_flag, 1'b0);
    wr(`DTC_ADDR_CTRL, 8'h00);
    rd(`DTC_ADDR_T0_LOW, 8'h01);
    rd(`DTC_ADDR_T0_HIGH, 8'h00);
    repeat (24) @(negedge clk);
    rd(`DTC_ADDR_T0_LOW, 8'h01);
    wr(`DTC_ADDR_MODE, 8'h00);
    wr(`DTC_ADDR_T1_LOW, 8'hFF);
    wr(`DTC_ADDR_T1_HIGH, 8'hFF);
    run(8'h40, 1);
    flag("timer1 flag", timer1_overflow_flag, 1'b1);
    ack_pulse(4'h2);
    flag("timer1 flag", timer1_overflow_flag, 1'b0);
    wr(`DTC_ADDR_CTRL, 8'h00);
    rd(`DTC_ADDR_T1_LOW, 8'hE0);
    rd(`DTC_ADDR_T1_HIGH, 8'h00);
    wr(`DTC_ADDR_MODE, 8'h02);
    wr(`DTC_ADDR_T0_HIGH, 8'hF0);
    wr(`DTC_ADDR_T0_LOW, 8'hFE);
    run(8'h10, 3);
    flag("timer0 flag", timer0_overflow_flag, 1'b1);
    wr(`DTC_ADDR_CTRL, 8'h00);
    rd(`DTC_ADDR_T0_LOW, 8'hF1);
    rd(`DTC_ADDR_T0_HIGH, 8'hF0);
    wr(`DTC_ADDR_MODE, 8'h30);
    wr(`DTC_ADDR_T1_LOW, 8'h10);
    run(8'h40, 2);
    rd(`DTC_ADDR_T1_LOW, 8'h10);
    // Stop timer 1 before the next mode, or it counts while loading
    wr(`DTC_ADDR_CTRL, 8'h00);
    wr(`DTC_ADDR_MODE, 8'h10);
    wr(`DTC_ADDR_T1_LOW, 8'hFF);
    wr(`DTC_ADDR_T1_HIGH, 8'h12);
    run(8'h40, 1);
    wr(`DTC_ADDR_CTRL, 8'h00);
    rd(`DTC_ADDR_T1_LOW, 8'h00);
    rd(`DTC_ADDR_T1_HIGH, 8'h13);
    wr(`DTC_ADDR_MODE, 8'h09);
    wr(`DTC_ADDR_T0_LOW, 8'h00);
    u_pins.set_irq(0, 1'b0);
    run(8'h10, 2);
    flag("irq0 flag", ext_irq0_flag, 1'b1);
    ack_pulse(4'h4);
    flag("irq0 flag", ext_irq0_flag, 1'b1);
    rd(`DTC_ADDR_T0_LOW, 8'h00);
    wr(`DTC_ADDR_CTRL, 8'h00);
    u_pins.set_irq(0, 1'b1);
    run(8'h10, 2);
    wr(`DTC_ADDR_CTRL, 8'h00);
    rd(`DTC_ADDR_T0_LOW, 8'h02);
    wr(`DTC_ADDR_MODE, 8'h90);
    wr(`DTC_ADDR_T1_LOW, 8'h00);
    u_pins.set_irq(1, 1'b0);
    run(8'h40, 2);
    rd(`DTC_ADDR_T1_LOW, 8'h00);
    u_pins.set_irq(1, 1'b1);
    wr(`DTC_ADDR_MODE, 8'h55);
    wr(`DTC_ADDR_T0_LOW, 8'h00);
    wr(`DTC_ADDR_T1_LOW, 8'h00);
    wr(`DTC_ADDR_CTRL, 8'h50);
    u_pins.count_pulses(0, 3);
    u_pins.count_pulses(1, 2);
    repeat (24) @(negedge clk);
    wr(`DTC_ADDR_CTRL, 8'h00);
    rd(`DTC_ADDR_T0_LOW, 8'h03);
    rd(`DTC_ADDR_T1_LOW, 8'h02);
    wr(`DTC_ADDR_MODE, 8'h03);
    wr(`DTC_ADDR_T0_LOW, 8'hFE);
    wr(`DTC_ADDR_T0_HIGH, 8'hFF);
    run(8'h50, 2);
    flag("timer0 flag", timer0_overflow_flag, 1'b1);
    flag("timer1 flag", timer1_overflow_flag, 1'b1);
    wr(`DTC_ADDR_CTRL, 8'h00);
    rd(`DTC_ADDR_T0_LOW, 8'h00);
    rd(`DTC_ADDR_T0_HIGH, 8'h01);
    wr(`DTC_ADDR_CTRL, 8'h05);
    repeat (6) @(negedge clk);
    flag("irq1 flag", ext_irq1_flag, 1'b0);
    u_pins.set_irq(1, 1'b0);
    repeat (3) @(negedge clk);
    u_pins.set_irq(1, 1'b1);
    repeat (6) @(negedge clk);
    flag("irq1 flag", ext_irq1_flag, 1'b1);
    ack_pulse(4'h8);
    flag("irq1 flag", ext_irq1_flag, 1'b0);
    report_and_stop();
  end
endmodule // tb_dtc_dual_timer
